/* ism_pkg.sv */
// Package for the image stamp and mirror block: register map, fields, types.
package ism_pkg;
	// Register byte offsets (one aligned word each).
	localparam logic [11:0] ISM_STAMP_CTRL_OFS = 12'h000;
	localparam logic [11:0] ISM_MIRROR_CTRL_OFS = 12'h004;
	localparam logic [11:0] ISM_SEQ_CTRL_OFS = 12'h008;
	localparam logic [11:0] ISM_TEST_CTRL_OFS = 12'h00C;
	localparam logic [11:0] ISM_STATUS_OFS = 12'h010;
	// Field layouts and reset values.
	localparam int ISM_SEQ_MODE_W = 2;
	localparam logic [1:0] ISM_SEQ_MODE_OFF = 2'h0;
	localparam logic [31:0] ISM_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] ISM_UNMAPPED_DATA = 32'h0000_0000;
	// Stamp geometry.
	localparam int ISM_STAMP_LEN = 11;
	localparam logic [7:0] ISM_FRAME_WRAP = 8'hFF;
	// Line widths of the two sensor variants.
	localparam int ISM_LINE_W_MAIN = 2352;
	localparam int ISM_LINE_W_ALT = 2320;
	localparam int ISM_PIX_W = 10;
	localparam int ISM_COORD_W = 16;
	// Pixel beat carried between stages.
	typedef struct packed {
		logic [ISM_PIX_W-1:0] data;
		logic sol;
		logic eol;
		logic last_line;
	} ism_pix_type;
	// Region geometry as carried for the current image.
	typedef struct packed {
		logic [ISM_COORD_W-1:0] col_start;
		logic [ISM_COORD_W-1:0] width;
		logic [ISM_COORD_W-1:0] line_start;
		logic [ISM_COORD_W-1:0] height;
	} ism_geom_type;
	typedef enum logic [1:0] {ISM_TP_STRIPE, ISM_TP_DIAG, ISM_TP_MOVE, ISM_TP_FLAT} ism_tp_type;
endpackage

/* ism_fifo.sv */
// Synchronous valid/ready FIFO with parameterised width and depth.
`timescale 1ns/1ps
module ism_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 32
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Fill side.
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side.
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr_r;
	logic [AW:0] rd_ptr_r;
	logic full;
	logic empty;

	// Extra pointer bit tells full from empty.
	assign empty = (wr_ptr_r == rd_ptr_r);
	assign full = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = mem[rd_ptr_r[AW-1:0]];

	// Storage write.
	always_ff @(posedge pclk) begin
		if (in_valid && !full) begin
			mem[wr_ptr_r[AW-1:0]] <= in_data;
		end
	end

	// Pointers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
		end else begin
			if (in_valid && !full) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (out_ready && !empty) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end
endmodule

/* ism_top.sv */
// Image stamp and mirror stage: APB registers, test pattern, line mirror, stamp.
//
// Notes on behaviour
// - With stamping on, the last 11 pixels of the last line become stamp values.
// - Stamp pixels one to three: sequence position, run count, frame count.
// - Stamp pixels four to eleven: high/low bytes of column, width, line, height.
// - Sequencer unused: position and run-count stamp pixels are zero.
// - 8-bit frame counter from zero, one step per image, wraps after 255.
// - Frame counter clears on reset and whenever stamping is off.
// - In 10-bit mode stamp pixels carry the byte low, two upper bits zero.
// - Software turns stamping on or off through the stamp control mode field.
// - Mirror on a 2352-pixel line swaps pixel n with pixel 2353 minus n.
// - The 2320-pixel variant reverses its full line the same way.
// - Region lines are reversed within their own width.
// - Reversal applies to every region of a running sequence.
// - Software turns mirroring on or off through the mirror control mode field.
// - A test mode replaces sensor data with one of four selectable patterns.
// - Sequencer trigger mode 0 means disabled, so the first two stamp pixels are 0.
`timescale 1ns/1ps
module ism_top #(
	parameter int PIX_W = ism_pkg::ISM_PIX_W,
	parameter int MAX_LINE = ism_pkg::ISM_LINE_W_MAIN,
	parameter int FIFO_DEPTH = 32
) (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Sequencer state for the current image.
	input wire logic [7:0] seq_position,
	input wire logic [7:0] seq_run_count,
	input wire ism_pkg::ism_geom_type geom,
	input wire logic frame_start,
	// Pixel input from sensor readout.
	input wire logic in_valid,
	output logic in_ready,
	input wire ism_pkg::ism_pix_type in_pix,
	// Pixel output toward the frame grabber.
	output logic out_valid,
	input wire logic out_ready,
	output ism_pkg::ism_pix_type out_pix
);
	import ism_pkg::*;

	localparam int LW = $clog2(MAX_LINE + 1);
	localparam int BW = $bits(ism_pix_type);

	logic stamp_en_r;
	logic mirror_en_r;
	logic [ISM_SEQ_MODE_W-1:0] seq_mode_r;
	logic test_en_r;
	ism_tp_type test_sel_r;
	logic ten_bit_r;
	logic [7:0] frame_cnt_r;

	////////////////////////////////////////////////////////////////////////////
	// APB register file. Zero wait states, so pready is always high.
	// Register map, one aligned word each:
	//   stamp control: bit 0 stamp enable, bit 1 ten-bit output mode.
	//   mirror control: bit 0 mirror enable.
	//   sequencer control: bits 1:0 trigger mode, zero meaning off.
	//   test control: bit 0 pattern enable, bits 2:1 pattern select.
	//   status: bits 7:0 frame counter, read only.
	// Unmapped offsets answer with an error and read as zero; writes there
	// are dropped, so software probing the map cannot disturb anything.
	logic apb_wr;
	logic mapped;
	assign apb_wr = psel && penable && pwrite;
	assign pready = 1'b1;
	assign mapped = (paddr == ISM_STAMP_CTRL_OFS) || (paddr == ISM_MIRROR_CTRL_OFS) ||
		(paddr == ISM_SEQ_CTRL_OFS) || (paddr == ISM_TEST_CTRL_OFS) ||
		(paddr == ISM_STATUS_OFS);
	assign pslverr = psel && penable && !mapped;

	// Control writes; bit 0 of the stamp, mirror and test words is the mode field, the sequencer mode is bits 1:0.
	// A write lands only in the access phase, so a setup cycle that is
	// abandoned by the master leaves every control untouched.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stamp_en_r <= ISM_CTRL_RST[0];
			mirror_en_r <= ISM_CTRL_RST[0];
			seq_mode_r <= ISM_SEQ_MODE_OFF;
			test_en_r <= ISM_CTRL_RST[0];
			test_sel_r <= ISM_TP_STRIPE;
			ten_bit_r <= ISM_CTRL_RST[0];
		end else if (apb_wr) begin
			case (paddr)
				ISM_STAMP_CTRL_OFS: begin
					stamp_en_r <= pwdata[0];
					ten_bit_r <= pwdata[1];
				end
				ISM_MIRROR_CTRL_OFS: mirror_en_r <= pwdata[0];
				ISM_SEQ_CTRL_OFS: seq_mode_r <= pwdata[ISM_SEQ_MODE_W-1:0];
				ISM_TEST_CTRL_OFS: begin
					test_en_r <= pwdata[0];
					test_sel_r <= ism_tp_type'(pwdata[2:1]);
				end
				default: begin
				end
			endcase
		end
	end

	// Read data is registered at the setup phase so it stands through access.
	// Loading it early keeps the address decode off the read data path,
	// which is why the slave can answer without a wait state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= ISM_UNMAPPED_DATA;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				ISM_STAMP_CTRL_OFS: prdata <= {30'h0000_0000, ten_bit_r, stamp_en_r};
				ISM_MIRROR_CTRL_OFS: prdata <= {31'h0000_0000, mirror_en_r};
				ISM_SEQ_CTRL_OFS: prdata <= {30'h0000_0000, seq_mode_r};
				ISM_TEST_CTRL_OFS: prdata <= {29'h0000_0000, test_sel_r, test_en_r};
				ISM_STATUS_OFS: prdata <= {24'h00_0000, frame_cnt_r};
				default: prdata <= ISM_UNMAPPED_DATA;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Input FIFO absorbs readout bursts while the mirror drains a line.
	// Once both line banks and the FIFO are full, in_ready drops and the
	// readout has to pause; no pixel is ever dropped inside the block.
	logic fifo_valid;
	logic fifo_ready;
	ism_pix_type fifo_pix;
	logic [BW-1:0] fifo_data;

	ism_fifo #(.WIDTH(BW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.in_data(in_pix),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_data(fifo_data)
	);
	assign fifo_pix = ism_pix_type'(fifo_data);

	////////////////////////////////////////////////////////////////////////////
	// Test pattern counters track column and line of the incoming stream.
	// The pattern replaces data before the mirror, so a mirrored test image
	// shows the gradient reversed just as a real scene would be.
	logic [LW-1:0] tp_col_r;
	logic [LW-1:0] tp_line_r;
	logic [PIX_W-1:0] tp_value;
	logic [PIX_W-1:0] tp_mask;
	ism_pix_type src_pix;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tp_col_r <= '0;
			tp_line_r <= '0;
		end else if (fifo_valid && fifo_ready) begin
			tp_col_r <= fifo_pix.eol ? '0 : tp_col_r + 1'b1;
			if (fifo_pix.eol) begin
				tp_line_r <= fifo_pix.last_line ? '0 : tp_line_r + 1'b1;
			end
		end
	end

	// Pattern select; 8-bit mode keeps the gradient within one byte.
	always_comb begin
		tp_mask = ten_bit_r ? {PIX_W{1'b1}} : PIX_W'(8'hFF);
		case (test_sel_r)
			ISM_TP_STRIPE: tp_value = PIX_W'(tp_col_r + 1'b1);
			ISM_TP_DIAG: tp_value = PIX_W'(tp_col_r + tp_line_r + 1'b1);
			ISM_TP_MOVE: tp_value = PIX_W'(tp_col_r + tp_line_r + frame_cnt_r + 1'b1);
			ISM_TP_FLAT: tp_value = PIX_W'(tp_line_r);
			default: tp_value = '0;
		endcase
		src_pix = fifo_pix;
		if (test_en_r) begin
			src_pix.data = tp_value & tp_mask;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mirror: two line buffers; one fills while the other drains reversed.
	// Line length comes from the eol marker, so region widths and both sensor
	// variants are handled alike at the cost of one line of latency.
	// A line may only start draining once its end marker has been stored,
	// because the first pixel out of a reversed line is the last pixel in.
	// The price is two full line buffers; a single buffer read and written
	// in place would save memory but stall the readout for a whole line.
	// Lines longer than MAX_LINE are cut at that length and treated as
	// complete, so a missing end marker cannot lock up the mirror.
	ism_pix_type lbuf [2][MAX_LINE];
	logic wr_bank_r;
	logic [LW-1:0] wr_cnt_r;
	logic [1:0] full_r;
	logic [LW-1:0] len_r [2];
	logic rd_bank_r;
	logic [LW-1:0] rd_cnt_r;
	logic mir_r [2];
	logic mir_valid;
	logic mir_ready;
	logic [LW-1:0] rd_idx;
	ism_pix_type mir_pix;
	logic fill_ok;
	logic wr_fire;
	logic rd_fire;
	logic rd_done;

	assign fill_ok = !full_r[wr_bank_r];
	assign fifo_ready = fill_ok;
	assign wr_fire = fifo_valid && fill_ok;
	assign mir_valid = full_r[rd_bank_r];
	assign rd_fire = mir_valid && mir_ready;
	assign rd_done = rd_fire && (rd_cnt_r == len_r[rd_bank_r] - 1'b1);
	// Reversed index: entry len-1-k, i.e. pixel n leaves as pixel len+1-n.
	assign rd_idx = mir_r[rd_bank_r] ? LW'(len_r[rd_bank_r] - 1'b1 - rd_cnt_r) : rd_cnt_r;
	assign mir_pix = lbuf[rd_bank_r][rd_idx];

	// Line store.
	// No reset on the storage: a bank is only read after it has been filled.
	always_ff @(posedge pclk) begin
		if (wr_fire) begin
			lbuf[wr_bank_r][wr_cnt_r] <= src_pix;
		end
	end

	// Fill side; mirror mode is latched per line so every region of a
	// sequence gets the same treatment and a change never splits a line.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_bank_r <= 1'b0;
			wr_cnt_r <= '0;
			len_r[0] <= '0;
			len_r[1] <= '0;
			mir_r[0] <= 1'b0;
			mir_r[1] <= 1'b0;
		end else if (wr_fire) begin
			if (src_pix.eol || wr_cnt_r == LW'(MAX_LINE - 1)) begin
				len_r[wr_bank_r] <= wr_cnt_r + 1'b1;
				mir_r[wr_bank_r] <= mirror_en_r;
				wr_bank_r <= !wr_bank_r;
				wr_cnt_r <= '0;
			end else begin
				wr_cnt_r <= wr_cnt_r + 1'b1;
			end
		end
	end

	// Bank full flags: set at end of fill, cleared at end of drain.
	// The set is written last so that it wins if both hit one bank in the
	// same cycle; losing a set there would drop a whole line.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			full_r <= 2'h0;
		end else begin
			if (rd_done) begin
				full_r[rd_bank_r] <= 1'b0;
			end
			if (wr_fire && (src_pix.eol || wr_cnt_r == LW'(MAX_LINE - 1))) begin
				full_r[wr_bank_r] <= 1'b1;
			end
		end
	end

	// Drain side.
	// The drain counter runs in output order whatever the mirror mode is.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_bank_r <= 1'b0;
			rd_cnt_r <= '0;
		end else if (rd_fire) begin
			if (rd_done) begin
				rd_cnt_r <= '0;
				rd_bank_r <= !rd_bank_r;
			end else begin
				rd_cnt_r <= rd_cnt_r + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Stamp stage, after the mirror so stamp bytes keep their order.
	// The stamp is placed by counting back from the end of the output line,
	// so it lands on the last eleven pixels for any line or region width.
	// A last line shorter than eleven pixels only carries the tail slots;
	// the leading stamp bytes then have no pixel to ride on.
	// Sequencer values and geometry are sampled as the stamp pixels leave,
	// so they must stay steady until the image has been sent.
	logic [LW-1:0] st_remain;
	logic [7:0] stamp_byte;
	logic stamp_hit;
	ism_pix_type st_pix;
	logic seq_on;
	logic [3:0] st_slot;
	logic out_load;

	// Pixels left in the line including this one, taken from the drain.
	assign st_remain = LW'(len_r[rd_bank_r] - rd_cnt_r);
	assign stamp_hit = stamp_en_r && mir_pix.last_line && (st_remain <= LW'(ISM_STAMP_LEN));
	assign st_slot = 4'(LW'(ISM_STAMP_LEN) - st_remain);
	assign seq_on = (seq_mode_r != ISM_SEQ_MODE_OFF);

	// Stamp byte by slot.
	// Slot zero is the first stamp pixel the grabber receives.
	always_comb begin
		case (st_slot)
			4'h0: stamp_byte = seq_on ? seq_position : 8'h00;
			4'h1: stamp_byte = seq_on ? seq_run_count : 8'h00;
			4'h2: stamp_byte = frame_cnt_r;
			4'h3: stamp_byte = geom.col_start[15:8];
			4'h4: stamp_byte = geom.col_start[7:0];
			4'h5: stamp_byte = geom.width[15:8];
			4'h6: stamp_byte = geom.width[7:0];
			4'h7: stamp_byte = geom.line_start[15:8];
			4'h8: stamp_byte = geom.line_start[7:0];
			4'h9: stamp_byte = geom.height[15:8];
			4'hA: stamp_byte = geom.height[7:0];
			default: stamp_byte = 8'h00;
		endcase
		st_pix = mir_pix;
		// Reversal moves the stored line markers, so they are rebuilt from
		// the drain position; the grabber always sees sol first, eol last.
		st_pix.sol = (rd_cnt_r == '0);
		st_pix.eol = (rd_cnt_r == LW'(len_r[rd_bank_r] - 1'b1));
		if (stamp_hit) begin
			st_pix.data = {{(PIX_W-8){1'b0}}, stamp_byte};
		end
	end

	// Frame counter; cleared while stamping is off.
	// Holding it clear rather than clearing once on the falling enable means
	// the first stamped image after a re-enable always counts from zero.
	// The frame start pulse must be a single cycle or it counts twice.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_cnt_r <= 8'h00;
		end else if (!stamp_en_r) begin
			frame_cnt_r <= 8'h00;
		end else if (frame_start) begin
			frame_cnt_r <= (frame_cnt_r == ISM_FRAME_WRAP) ? 8'h00 : frame_cnt_r + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output register; a single skid-free stage that loads when empty or taken.
	// Ready to the mirror is combinational from out_ready, which is cheap but
	// leaves one gate level between the grabber and the line buffer read.
	// The beat held here never changes while the grabber stalls.
	assign out_load = !out_valid || out_ready;
	assign mir_ready = out_load;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid <= 1'b0;
			out_pix <= '0;
		end else if (out_load) begin
			out_valid <= mir_valid;
			if (mir_valid) begin
				out_pix <= st_pix;
			end
		end
	end
endmodule

/* ism_top_chk.sv */
// Checker for the stamp and mirror block, bound to its top module.
`timescale 1ns/1ps
module ism_top_chk #(
	parameter int PIX_W = 10,
	parameter int MAX_LINE = 2352,
	parameter int FIFO_DEPTH = 32
) (
	// Clock, reset and APB.
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sequencer state and video output.
	input wire logic [7:0] seq_position,
	input wire logic [7:0] seq_run_count,
	input wire ism_pkg::ism_geom_type geom,
	input wire logic frame_start,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire ism_pkg::ism_pix_type out_pix
);
	import ism_pkg::*;
	logic stamp_en_r, acc, wr, done, mapped;
	logic [1:0] seqm_r;
	logic [7:0] fc_r;
	logic [109:0] hist_r;
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign done = out_valid && out_ready && out_pix.eol && out_pix.last_line && stamp_en_r;
	assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Low bytes of seven stamp beats, oldest first.
	function automatic logic [55:0] bytes7(input logic [69:0] h);
		for (int i = 0; i < 7; i++) bytes7[i*8 +: 8] = h[i*10 +: 8];
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	// Shadow of the controls; the frame count is cleared while stamping is off.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stamp_en_r <= 1'b0;
			seqm_r <= 2'h0;
			fc_r <= 8'h00;
		end else begin
			if (wr && paddr == ISM_STAMP_CTRL_OFS) stamp_en_r <= pwdata[0];
			if (wr && paddr == ISM_SEQ_CTRL_OFS) seqm_r <= pwdata[1:0];
			fc_r <= !stamp_en_r ? 8'h00 : fc_r + {7'h00, frame_start};
		end
	end
	// The last eleven beats taken by the grabber, newest at the bottom.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) hist_r <= '0;
		else if (out_valid && out_ready) hist_r <= {hist_r[99:0], out_pix.data};
	end
	////////////////////////////////////////////////////////////////////////////////
	a_apb_ready: assert property (psel |-> pready) else $error("pready low");
	a_unmapped_err: assert property (acc && !mapped |-> pslverr) else $error("no slverr");
	a_mapped_ok: assert property (acc && mapped |-> !pslverr) else $error("false slverr");
	a_out_hold: assert property (
		out_valid && !out_ready |=> out_valid && $stable(out_pix))
		else $error("output beat changed while stalled");
	a_tail_byte: assert property (done |-> out_pix.data == {2'b00, geom.height[7:0]})
		else $error("last stamp beat wrong");
	a_seq_zero: assert property (
		done && seqm_r == ISM_SEQ_MODE_OFF |=> hist_r[109:90] == 20'h00000)
		else $error("sequencer beats not zero");
	a_seq_vals: assert property (done && seqm_r != ISM_SEQ_MODE_OFF |=>
		hist_r[109:90] == {2'b00, $past(seq_position), 2'b00, $past(seq_run_count)})
		else $error("sequencer beats wrong");
	a_frame_byte: assert property (done |=> hist_r[89:80] == {2'b00, $past(fc_r)})
		else $error("frame count beat wrong");
	a_geom_bytes: assert property (done |=> bytes7(hist_r[79:10]) == $past(geom[63:8]))
		else $error("geometry beats wrong");
	a_fc_clear: assert property (acc && !pwrite && paddr == ISM_STATUS_OFS && !stamp_en_r &&
		$past(!stamp_en_r, 3) |-> prdata[7:0] == 8'h00) else $error("count not cleared");
	c_stamp: cover property (done);
	c_seq_stamp: cover property (done && seqm_r != ISM_SEQ_MODE_OFF);
	c_stall: cover property (out_valid && !out_ready);
	c_slverr: cover property (acc && pslverr);
endmodule
bind ism_top ism_top_chk #(.PIX_W(PIX_W), .MAX_LINE(MAX_LINE), .FIFO_DEPTH(FIFO_DEPTH)) u_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.seq_position, .seq_run_count, .geom, .frame_start, .out_valid, .out_ready, .out_pix);

/* ism_grabber.sv */
// Frame grabber model taking the video output with back-pressure.
`timescale 1ns/1ps
module ism_grabber (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Stall request and the ready returned to the block.
	input wire logic hold,
	output logic out_ready
);
	logic [3:0] pat_r;
	// A real grabber pauses at odd beats, so ready drops three cycles in fifteen.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) pat_r <= 4'h9;
		else pat_r <= {pat_r[2:0], pat_r[3] ^ pat_r[2]};
	end
	assign out_ready = !hold && (pat_r[0] || pat_r[1]);
endmodule

/* tb_ism_top.sv */
// Self-checking bench for the image stamp and mirror block.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
	$display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_ism_top;
	import ism_pkg::*;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic in_valid = 1'b0, frame_start = 1'b0, hold = 1'b0, refused = 1'b0, tp_on = 1'b0;
	logic stamp_on = 1'b0, seq_on = 1'b0, in_ready, out_valid, out_ready, pready, pslverr;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic [7:0] seq_position = 8'h00, seq_run_count = 8'h00, fc = 8'h00, er;
	logic [7:0] stb [11];
	logic [15:0] rnd = 16'h0055;
	ism_geom_type geom = '0;
	ism_pix_type in_pix = '0, out_pix, ep;
	ism_pix_type pexp [$];
	logic [7:0] rexp [$];
	int mismatches = 0, tests_run = 0;
	ism_top #(.FIFO_DEPTH(32)) u_ism_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .seq_position, .seq_run_count, .geom, .frame_start,
		.in_valid, .in_ready, .in_pix, .out_valid, .out_ready, .out_pix);
	ism_grabber u_ism_grabber (.pclk, .presetn, .hold, .out_ready);
	initial begin
		forever #5 pclk = ~pclk;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// A wait that runs out is counted and ends the run at once.
	task automatic wait_fail(input int n, input int lim);
		if (n >= lim) begin
			mismatches++;
			final_report;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// APB transfer: request held until pready is seen high.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
		wait_fail(n, 50);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] v);
		rexp.push_back(v);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic pulse;
		frame_start <= 1'b1;
		@(posedge pclk);
		frame_start <= 1'b0;
		@(posedge pclk);
		if (stamp_on) fc++;
	endtask
	// One line of random video; notes the mirrored and stamped result first.
	task automatic line(input int n, input logic m, input logic l);
		logic [9:0] d [];
		ism_pix_type e;
		int w;
		d = new[n];
		stb[0] = seq_on ? seq_position : 8'h00;
		stb[1] = seq_on ? seq_run_count : 8'h00;
		stb[2] = fc;
		for (int i = 0; i < 8; i++) stb[3+i] = geom[63-8*i -: 8];
		for (int i = 0; i < n; i++) begin
			rnd = lfsr(rnd);
			d[i] = rnd[9:0];
		end
		for (int k = 0; k < n; k++) begin
			e.data = m ? d[n-1-k] : d[k];
			if (tp_on) e.data = m ? 10'(n - k) : 10'(k + 1);
			if (l && stamp_on && k >= n - 11) e.data = {2'b00, stb[k-n+11]};
			e.sol = (k == 0);
			e.eol = (k == n - 1);
			e.last_line = l;
			pexp.push_back(e);
		end
		for (int i = 0; i < n; i++) begin
			in_valid <= 1'b1;
			in_pix <= {d[i], i == 0, i == n - 1, l};
			w = 0;
			do begin @(posedge pclk); w++; end while (in_ready !== 1'b1 && w < 3000);
			wait_fail(w, 3000);
		end
		in_valid <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic drain;
		int n;
		n = 0;
		while (pexp.size() != 0 && n < 20000) begin @(posedge pclk); n++; end
		wait_fail(n, 20000);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Each accepted beat and each read is matched to the oldest note.
	always @(posedge pclk) begin
		if (in_valid && in_ready === 1'b0) refused <= 1'b1;
		if (out_valid && out_ready) begin
			ep = (pexp.size() > 0) ? pexp.pop_front() : 'x;
			`CHK(out_pix, ep)
		end
		if (psel && penable && !pwrite) begin
			er = (rexp.size() > 0) ? rexp.pop_front() : 'x;
			`CHK(prdata[7:0], er)
		end
	end
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(ISM_STATUS_OFS, 8'h00);
		rd(12'h020, 8'h00);
		$display("test reset done");
		line(16, 1'b0, 1'b0);
		drain;
		apb(1'b1, ISM_MIRROR_CTRL_OFS, 32'h0000_0001);
		line(8, 1'b1, 1'b0);
		line(ISM_LINE_W_ALT, 1'b1, 1'b0);
		line(ISM_LINE_W_MAIN, 1'b1, 1'b0);
		drain;
		$display("test mirror done");
		for (int t = 0; t < 2; t++) begin
			rnd = lfsr(rnd);
			seq_position <= rnd[7:0];
			seq_run_count <= rnd[15:8];
			geom <= {rnd, ~rnd, rnd ^ 16'h0F0F, rnd + 16'h0001};
			seq_on = t[0];
			stamp_on = 1'b1;
			apb(1'b1, ISM_SEQ_CTRL_OFS, {31'h0, seq_on});
			apb(1'b1, ISM_STAMP_CTRL_OFS, {30'h0, seq_on, 1'b1});
			repeat (3) pulse;
			line(20, 1'b1, 1'b0);
			line(14, 1'b1, 1'b1);
			drain;
		end
		$display("test stamp done");
		repeat (250) pulse;
		rd(ISM_STATUS_OFS, 8'h00);
		pulse;
		rd(ISM_STATUS_OFS, 8'h01);
		apb(1'b1, ISM_STAMP_CTRL_OFS, 32'h0000_0000);
		stamp_on = 1'b0;
		fc = 8'h00;
		repeat (2) @(posedge pclk);
		pulse;
		rd(ISM_STATUS_OFS, 8'h00);
		$display("test frame count done");
		for (int p = 0; p < 4; p++) begin
			apb(1'b1, ISM_TEST_CTRL_OFS, {29'h0, p[1:0], 1'b1});
			rd(ISM_TEST_CTRL_OFS, {5'h00, p[1:0], 1'b1});
		end
		// Stripe pattern in 8-bit mode replaces the video, then is mirrored.
		apb(1'b1, ISM_TEST_CTRL_OFS, 32'h0000_0001);
		tp_on = 1'b1;
		line(8, 1'b1, 1'b0);
		drain;
		tp_on = 1'b0;
		apb(1'b1, ISM_TEST_CTRL_OFS, 32'h0000_0000);
		apb(1'b1, ISM_MIRROR_CTRL_OFS, 32'h0000_0000);
		$display("test patterns done");
		// Grabber stalls while lines pile up, so the input must refuse.
		hold <= 1'b1;
		fork
			begin
				repeat (600) @(posedge pclk);
				hold <= 1'b0;
			end
		join_none
		repeat (16) line(8, 1'b0, 1'b0);
		drain;
		`CHK(refused, 1'b1)
		$display("test fill done");
		final_report;
	end
endmodule
